// File: rtl/occ_pkg.sv
// Constants, register map and divider tables of the oscillator clock control.
// Assumes a 50 MHz system clock; the sources are modelled as tick generators on it.
package occ_pkg;
    localparam longint SYS_HZ = 50000000;
    localparam longint RC_FAST_HZ = 2000000;
    localparam longint RC_SLOW_HZ = 25000;
    localparam longint SLOW_CHZ = 173000;
    localparam longint RING_HZ = 27000000;
    localparam int CNT_W = 15;
    localparam int RC_FAST_CYC = ((SYS_HZ / RC_FAST_HZ) < 1) ? 1 : int'(SYS_HZ / RC_FAST_HZ);
    localparam int RC_SLOW_CYC = ((SYS_HZ / RC_SLOW_HZ) < 1) ? 1 : int'(SYS_HZ / RC_SLOW_HZ);
    localparam int SLOW_CYC = int'((SYS_HZ * 100) / SLOW_CHZ);
    localparam int RING_CYC = ((SYS_HZ / RING_HZ) < 1) ? 1 : int'(SYS_HZ / RING_HZ);
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_DIV = 8'h04;
    localparam logic [7:0] ADDR_STAT = 8'h08;
    localparam int CTRL_RC_STOP = 0;
    localparam int CTRL_RC_RUN = 1;
    localparam int CTRL_SLOW_STOP = 2;
    localparam int CTRL_SLOW_RUN = 3;
    localparam int CTRL_RING_STOP = 4;
    localparam int CTRL_RING_RUN = 5;
    localparam int CTRL_RC_FAST = 8;
    localparam logic [8:0] CTRL_RST = 9'h000;
    localparam logic [15:0] DIV_RST = 16'h0000;
    localparam logic [8:0] CTRL_MASK = 9'h13F;
    localparam logic [15:0] DIV_MASK = 16'h773F;
    localparam int DIV_RC_PRE = 0;
    localparam int DIV_SLOW_PRE = 2;
    localparam int DIV_RING_PRE = 4;
    localparam int DIV_RC_S2 = 8;
    localparam int DIV_RING_S2 = 12;
    localparam int STAT_RUN = 0;
    localparam int STAT_REQ = 8;
    localparam int STAT_HALT = 16;
    localparam logic [7:0] RC_PRE_TAB [4] = '{8'h01, 8'h02, 8'h04, 8'h08};
    localparam logic [7:0] SLOW_PRE_TAB [4] = '{8'h01, 8'h02, 8'h04, 8'h10};
    localparam logic [7:0] RING_PRE_TAB [4] = '{8'h01, 8'h04, 8'h08, 8'h10};
    localparam logic [7:0] S2_TAB [8] = '{8'h01, 8'h02, 8'h04, 8'h08,
                                          8'h10, 8'h20, 8'h40, 8'h80};
endpackage : occ_pkg

// File: rtl/occ_osc.sv
// Source tick generator: one pulse every i_period cycles while enabled.
// Assumes i_period is at least one; the count restarts whenever disabled.
`timescale 1ns/1ps
module occ_osc (
    // Clock and reset.
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // Control.
    input wire logic i_en,
    input wire logic [occ_pkg::CNT_W-1:0] i_period,
    // Tick out.
    output logic o_tick
);
    import occ_pkg::*;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    wire last = (cnt_q >= i_period - CNT_W'(1));

    assign cnt_d = (!i_en || last) ? '0 : cnt_q + CNT_W'(1);
    assign o_tick = i_en && last;

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end
endmodule : occ_osc

// File: rtl/occ_div.sv
// Divider stage: passes one input tick out of every i_ratio ticks.
// Assumes i_ratio is at least one; a changed ratio applies at once to the running count.
`timescale 1ns/1ps
module occ_div (
    // Clock and reset.
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // Input ticks and ratio.
    input wire logic i_tick,
    input wire logic [7:0] i_ratio,
    // Divided ticks.
    output logic o_tick
);
    logic [7:0] cnt_q;
    logic [7:0] cnt_d;
    wire last = (cnt_q >= i_ratio - 8'h01);

    assign cnt_d = !i_tick ? cnt_q : (last ? 8'h00 : cnt_q + 8'h01);
    assign o_tick = i_tick && last;

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            cnt_q <= 8'h00;
        end else begin
            cnt_q <= cnt_d;
        end
    end
endmodule : occ_div

// File: rtl/occ_top.sv
// Oscillator clock control: three sources, their dividers and run control.
// Assumes an APB master on the system clock and synchronous matrix inputs.
//
// Implementation choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
module occ_top #(
    parameter int SLOW_CYC_P = occ_pkg::SLOW_CYC
) (
    // Clock and reset.
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // APB slave.
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // Matrix halt inputs, bit 0 RC, bit 1 slow, bit 2 ring.
    input wire logic [2:0] i_source_halt_input,
    // Turn-on requests per source: delay counter, converter, pulse-width unit.
    input wire logic [2:0] i_dly_req,
    input wire logic [2:0] i_adc_req,
    input wire logic [2:0] i_pwm_req,
    // Matrix clock lines and run state.
    output logic o_mtx_in48,
    output logic o_mtx_in49,
    output logic o_mtx_in50,
    output logic [2:0] o_src_run
);
    import occ_pkg::*;

    // ------------------------------------------------------------
    // Register interface
    // ------------------------------------------------------------
    logic [8:0] ctrl_q;
    logic [15:0] div_q;
    logic pready_q;
    logic [31:0] prdata_q;
    logic pslverr_q;
    logic [2:0] run_q;
    logic mtx48_q;
    logic mtx49_q;
    logic mtx50_q;

    wire hit_ctrl = (i_paddr == ADDR_CTRL);
    wire hit_div = (i_paddr == ADDR_DIV);
    wire hit_stat = (i_paddr == ADDR_STAT);
    wire access = i_psel && i_penable && !pready_q;
    wire fire = i_psel && i_penable && pready_q;
    wire wr_ctrl = fire && i_pwrite && hit_ctrl;
    wire wr_div = fire && i_pwrite && hit_div;
    wire bad = !(hit_ctrl || hit_div || hit_stat) || (i_pwrite && hit_stat);

    // ------------------------------------------------------------
    // Run control
    // ------------------------------------------------------------
    wire [2:0] stop_en = {ctrl_q[CTRL_RING_STOP], ctrl_q[CTRL_SLOW_STOP],
                          ctrl_q[CTRL_RC_STOP]};
    wire [2:0] run_mode = {ctrl_q[CTRL_RING_RUN], ctrl_q[CTRL_SLOW_RUN],
                           ctrl_q[CTRL_RC_RUN]};
    wire [2:0] turn_on = run_mode | i_dly_req | i_adc_req | i_pwm_req;
    wire [2:0] halted = stop_en & i_source_halt_input;
    wire [2:0] run_d = turn_on & ~halted;

    logic [31:0] rd_mux;
    assign rd_mux = hit_ctrl ? {23'h00_0000, ctrl_q} :
                    hit_div ? {16'h0000, div_q} :
                    hit_stat ? {13'h0000, i_source_halt_input, 5'h00, turn_on,
                                5'h00, run_q} : 32'h0000_0000;

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            pready_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else begin
            pready_q <= access;
            prdata_q <= access && !i_pwrite ? rd_mux : 32'h0000_0000;
            pslverr_q <= access && bad;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            ctrl_q <= CTRL_RST;
            div_q <= DIV_RST;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= i_pwdata[8:0] & CTRL_MASK;
            end
            if (wr_div) begin
                div_q <= i_pwdata[15:0] & DIV_MASK;
            end
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            run_q <= 3'h0;
        end else begin
            run_q <= run_d;
        end
    end

    // ------------------------------------------------------------
    // Sources
    // ------------------------------------------------------------
    logic rc_tick;
    logic slow_tick;
    logic ring_tick;
    wire [CNT_W-1:0] rc_period = ctrl_q[CTRL_RC_FAST] ? CNT_W'(RC_FAST_CYC)
                                                      : CNT_W'(RC_SLOW_CYC);

    occ_osc u_rc_osc (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_en(run_q[0]),
        .i_period(rc_period),
        .o_tick(rc_tick)
    );

    occ_osc u_slow_osc (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_en(run_q[1]),
        .i_period(CNT_W'(SLOW_CYC_P)),
        .o_tick(slow_tick)
    );

    occ_osc u_ring_osc (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_en(run_q[2]),
        .i_period(CNT_W'(RING_CYC)),
        .o_tick(ring_tick)
    );

    // ------------------------------------------------------------
    // Divider chains
    // ------------------------------------------------------------
    logic rc_pre_tick;
    logic slow_pre_tick;
    logic ring_pre_tick;
    logic rc_s2_tick;
    logic ring_s2_tick;
    wire [7:0] rc_pre_ratio = RC_PRE_TAB[div_q[DIV_RC_PRE +: 2]];
    wire [7:0] slow_pre_ratio = SLOW_PRE_TAB[div_q[DIV_SLOW_PRE +: 2]];
    wire [7:0] ring_pre_ratio = RING_PRE_TAB[div_q[DIV_RING_PRE +: 2]];
    wire [7:0] rc_s2_ratio = S2_TAB[div_q[DIV_RC_S2 +: 3]];
    wire [7:0] ring_s2_ratio = S2_TAB[div_q[DIV_RING_S2 +: 3]];

    occ_div u_rc_pre (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_tick(rc_tick),
        .i_ratio(rc_pre_ratio),
        .o_tick(rc_pre_tick)
    );

    occ_div u_rc_s2 (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_tick(rc_pre_tick),
        .i_ratio(rc_s2_ratio),
        .o_tick(rc_s2_tick)
    );

    occ_div u_slow_pre (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_tick(slow_tick),
        .i_ratio(slow_pre_ratio),
        .o_tick(slow_pre_tick)
    );

    occ_div u_ring_pre (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_tick(ring_tick),
        .i_ratio(ring_pre_ratio),
        .o_tick(ring_pre_tick)
    );

    occ_div u_ring_s2 (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_tick(ring_pre_tick),
        .i_ratio(ring_s2_ratio),
        .o_tick(ring_s2_tick)
    );

    // ------------------------------------------------------------
    // Matrix clock lines
    // ------------------------------------------------------------
    // Each line toggles once per divided tick, so its period is two ticks.
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            mtx48_q <= 1'b0;
            mtx49_q <= 1'b0;
            mtx50_q <= 1'b0;
        end else begin
            mtx48_q <= mtx48_q ^ ring_s2_tick;
            mtx49_q <= mtx49_q ^ rc_s2_tick;
            mtx50_q <= mtx50_q ^ slow_pre_tick;
        end
    end

    assign o_prdata = prdata_q;
    assign o_pready = pready_q;
    assign o_pslverr = pslverr_q;
    assign o_mtx_in48 = mtx48_q;
    assign o_mtx_in49 = mtx49_q;
    assign o_mtx_in50 = mtx50_q;
    assign o_src_run = run_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence s_setup;
        i_psel && !i_penable;
    endsequence

    sequence s_access;
        i_psel && i_penable && !pready_q;
    endsequence

    property p_apb_answer;
        @(posedge i_sys_clk) disable iff (i_rst)
        s_setup ##1 s_access |=> pready_q;
    endproperty
    a_apb_answer: assert property (p_apb_answer) else $error("APB answer late");

    property p_ctrl_write;
        @(posedge i_sys_clk) disable iff (i_rst)
        wr_ctrl |=> ctrl_q == ($past(i_pwdata[8:0]) & CTRL_MASK);
    endproperty
    a_ctrl_write: assert property (p_ctrl_write)
        else $error("Control write lost");

    property p_halt_stops;
        @(posedge i_sys_clk) disable iff (i_rst)
        stop_en[0] && i_source_halt_input[0] |=> !run_q[0] ##1 !rc_tick;
    endproperty
    a_halt_stops: assert property (p_halt_stops)
        else $error("Halted RC source still runs");

    property p_halt_ignored;
        @(posedge i_sys_clk) disable iff (i_rst)
        !stop_en[2] && run_mode[2] |=> run_q[2];
    endproperty
    a_halt_ignored: assert property (p_halt_ignored)
        else $error("Ring source stopped while forced on");

    property p_auto_off;
        @(posedge i_sys_clk) disable iff (i_rst)
        !run_mode[1] && !i_dly_req[1] && !i_adc_req[1] && !i_pwm_req[1] |=> !run_q[1];
    endproperty
    a_auto_off: assert property (p_auto_off)
        else $error("Slow source runs without request");

    property p_req_on;
        @(posedge i_sys_clk) disable iff (i_rst)
        !stop_en[0] && (i_dly_req[0] || i_adc_req[0] || i_pwm_req[0]) |=> run_q[0];
    endproperty
    a_req_on: assert property (p_req_on)
        else $error("Requested RC source not running");

    property p_slow_line;
        @(posedge i_sys_clk) disable iff (i_rst)
        slow_pre_tick |=> mtx50_q != $past(mtx50_q);
    endproperty
    a_slow_line: assert property (p_slow_line)
        else $error("Line 50 missed a slow tick");

    property p_ring_line;
        @(posedge i_sys_clk) disable iff (i_rst)
        !ring_s2_tick |=> $stable(mtx48_q);
    endproperty
    a_ring_line: assert property (p_ring_line)
        else $error("Line 48 moved without a tick");

    property p_stage2_needs_pre;
        @(posedge i_sys_clk) disable iff (i_rst)
        rc_s2_tick |-> rc_pre_tick && rc_tick;
    endproperty
    a_stage2_needs_pre: assert property (p_stage2_needs_pre)
        else $error("Second stage ticked alone");

    property p_idle_quiet;
        @(posedge i_sys_clk) disable iff (i_rst)
        !pready_q |-> prdata_q == 32'h0000_0000 && !pslverr_q;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet)
        else $error("Bus outputs not quiet outside an answer");

    property p_halt_all;
        @(posedge i_sys_clk) disable iff (i_rst)
        halted != 3'h0 |=> (run_q & $past(halted)) == 3'h0;
    endproperty
    a_halt_all: assert property (p_halt_all)
        else $error("Halted source still runs");

    property p_rc_line;
        @(posedge i_sys_clk) disable iff (i_rst)
        rc_s2_tick |=> mtx49_q != $past(mtx49_q);
    endproperty
    a_rc_line: assert property (p_rc_line)
        else $error("Line 49 missed an RC tick");
endmodule : occ_top

// File: verification/occ_far_model.sv
// Far-side model: matrix halt lines and macrocell turn-on requests.
// Assumes bench commands; drives the design just after each rising edge.
`timescale 1ns/1ps
module occ_far_model (
    // Clock.
    input wire logic i_sys_clk,
    // Bench commands.
    input wire logic [2:0] i_halt_cmd,
    input wire logic [8:0] i_req_cmd,
    // Lines to the design.
    output logic [2:0] o_halt,
    output logic [2:0] o_dly,
    output logic [2:0] o_adc,
    output logic [2:0] o_pwm
);
    always @(posedge i_sys_clk) begin
        o_halt <= i_halt_cmd;
        {o_pwm, o_adc, o_dly} <= i_req_cmd;
    end
endmodule : occ_far_model

// File: verification/occ_top_tb_top.sv
// Self-checking bench for the oscillator clock control.
// Assumes the far-side model is compiled first and a 50 MHz clock.
`timescale 1ns/1ps
module occ_top_tb_top;
    import occ_pkg::*;
    localparam int SLOW_P = 20;
    logic i_sys_clk = 1'b0;
    logic i_rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic pready, pslverr, err;
    logic [2:0] halt_cmd = 3'h0;
    logic [8:0] req_cmd = 9'h000;
    logic [2:0] halt, dly, adc, pwm, run, lines, lv;
    logic in48, in49, in50;
    int error_cnt = 0;
    int total_checks = 0;
    int rc_r[4] = '{1, 2, 4, 8};
    int slow_r[4] = '{1, 2, 4, 16};
    int ring_r[4] = '{1, 4, 8, 16};
    assign lines = {in50, in49, in48};

    occ_top #(.SLOW_CYC_P(SLOW_P)) occ_top_i (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
        .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
        .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .i_source_halt_input(halt), .i_dly_req(dly), .i_adc_req(adc), .i_pwm_req(pwm),
        .o_mtx_in48(in48), .o_mtx_in49(in49), .o_mtx_in50(in50), .o_src_run(run));
    occ_far_model occ_far_model_i (.i_sys_clk(i_sys_clk), .i_halt_cmd(halt_cmd),
        .i_req_cmd(req_cmd), .o_halt(halt), .o_dly(dly), .o_adc(adc), .o_pwm(pwm));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    // One APB transfer; the request holds until the edge that samples pready high.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       input logic [31:0] exp, input logic exp_err);
        logic ok;
        @(posedge i_sys_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge i_sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge i_sys_clk);
        end while (pready !== 1'b1);
        ok = pready;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        chk({30'h0, ok, err}, {30'h0, 1'b1, exp_err}, "answer");
        if (!wr && !exp_err) chk(rd, exp, "read data");
    endtask : apb

    task automatic run_case(input logic [8:0] c, input logic [2:0] h, input logic [8:0] q,
                            input logic [2:0] e);
        logic [2:0] on;
        on = {c[CTRL_RING_RUN], c[CTRL_SLOW_RUN], c[CTRL_RC_RUN]} | q[2:0] | q[5:3] | q[8:6];
        apb(1'b1, ADDR_CTRL, {23'h0, c}, 32'h0, 1'b0);
        @(posedge i_sys_clk);
        halt_cmd <= h;
        req_cmd <= q;
        repeat (4) @(negedge i_sys_clk);
        chk({29'h0, run}, {29'h0, e}, "run state");
        apb(1'b0, ADDR_STAT, 32'h0, {13'h0, h, 5'h0, on, 5'h0, e}, 1'b0);
    endtask : run_case

    task automatic tog(input int s, output int n);
        logic v;
        n = 0;
        v = lines[s];
        do begin
            @(negedge i_sys_clk);
            n++;
        end while (lines[s] === v && n < 5000);
    endtask : tog

    // The first toggles after a ratio change may still follow the old ratio.
    task automatic period(input int dv, input int s, input int e);
        int n;
        apb(1'b1, ADDR_DIV, 32'(dv), 32'h0, 1'b0);
        repeat (4) tog(s, n);
        chk(32'(n), 32'(e), "line half period");
    endtask : period

    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : end_sim

    // ------------------------------------------------------------
    // Clock, watchdog and tests
    // ------------------------------------------------------------
    initial begin
        forever #10 i_sys_clk = ~i_sys_clk;
    end

    // The tests take about 15,000 cycles; the watchdog allows more than three times that.
    initial begin
        repeat (50000) @(posedge i_sys_clk);
        error_cnt++;
        end_sim();
    end

    initial begin
        repeat (3) @(posedge i_sys_clk);
        i_rst <= 1'b0;
        apb(1'b0, ADDR_CTRL, 32'h0, 32'h0, 1'b0);
        apb(1'b0, ADDR_DIV, 32'h0, 32'h0, 1'b0);
        apb(1'b0, ADDR_STAT, 32'h0, 32'h0, 1'b0);
        apb(1'b0, 8'h0C, 32'h0, 32'h0, 1'b1);
        apb(1'b1, ADDR_STAT, 32'hFFFF_FFFF, 32'h0, 1'b1);
        apb(1'b1, ADDR_CTRL, 32'hFFFF_FFFF, 32'h0, 1'b0);
        apb(1'b0, ADDR_CTRL, 32'h0, 32'h0000_013F, 1'b0);
        apb(1'b1, ADDR_DIV, 32'hFFFF_FFFF, 32'h0, 1'b0);
        apb(1'b0, ADDR_DIV, 32'h0, 32'h0000_773F, 1'b0);
        $display("test registers done");
        run_case(9'h000, 3'h0, 9'h000, 3'h0);
        run_case(9'h000, 3'h0, 9'h001, 3'h1);
        run_case(9'h000, 3'h0, 9'h010, 3'h2);
        run_case(9'h000, 3'h0, 9'h100, 3'h4);
        run_case(9'h02A, 3'h0, 9'h000, 3'h7);
        run_case(9'h03F, 3'h7, 9'h1FF, 3'h0);
        run_case(9'h03F, 3'h2, 9'h000, 3'h5);
        run_case(9'h02A, 3'h7, 9'h000, 3'h7);
        run_case(9'h13F, 3'h7, 9'h000, 3'h0);
        lv = lines;
        repeat (300) @(negedge i_sys_clk);
        chk({29'h0, lines}, {29'h0, lv}, "lines held");
        $display("test run control done");
        run_case(9'h02A, 3'h0, 9'h000, 3'h7);
        period(0, 1, RC_SLOW_CYC);
        run_case(9'h12A, 3'h0, 9'h000, 3'h7);
        for (int i = 0; i < 4; i++) begin
            period(i << DIV_RING_PRE, 0, RING_CYC * ring_r[i]);
            period(i << DIV_RC_PRE, 1, RC_FAST_CYC * rc_r[i]);
            period(i << DIV_SLOW_PRE, 2, SLOW_P * slow_r[i]);
        end
        for (int i = 0; i < 8; i++) begin
            period(i << DIV_RING_S2, 0, RING_CYC * (1 << i));
        end
        period((3 << DIV_RC_S2) | 1, 1, RC_FAST_CYC * 16);
        $display("test clock lines done");
        // Reset in mid-run: run state, lines and registers return to zero.
        @(posedge i_sys_clk);
        i_rst <= 1'b1;
        repeat (3) @(posedge i_sys_clk);
        i_rst <= 1'b0;
        chk({26'h0, run, lines}, 32'h0, "reset outputs");
        apb(1'b0, ADDR_CTRL, 32'h0, 32'h0, 1'b0);
        apb(1'b0, ADDR_DIV, 32'h0, 32'h0, 1'b0);
        $display("test reset done");
        end_sim();
    end
endmodule : occ_top_tb_top
